// >>> hdl/gmch_device.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// RL1: latency is unsigned 16-bit microsecond count
// RL2: latency sent upper byte first
// RL3: latency only in external-trigger datagrams
// RL4: maintenance entry sends info listing immediately
// RL5: sampling continues during maintenance mode
// RL6: no measurement datagrams in maintenance; discarded
// RL7: external reset in maintenance reloads config
// RL8: exit command parameter picks init or normal
// RL9: exit to normal keeps unsaved config changes
// RL10: each self-check failure sets own bit
// RL11: status bits describe current datagram only
// RL12: host sends normal commands upper case
// RL13: five normal commands decoded
// RL14: commands execute only on terminator
// RL15: no echo, no error messages
// RL16: partial or wrong sequences do nothing
// RL17: special datagram replaces next measurement
// RL18: increment dropped after special datagram
// RL19: reset command does full unit reset
// RL20: finish current datagram before maintenance
// RL21: increment covers all samples since last
// RL22: matcher restarts on non-extending character
module gmch_device
    import gmch_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    gmch_link_if.device link,
    input wire logic sample_valid_i,
    input wire logic [23:0] sample_angle_i,
    input wire logic [7:0] check_fail_i,
    input wire logic ext_trigger_i,
    input wire logic [15:0] latency_us_i,
    input wire logic incr_angle_mode_i,
    input wire logic maint_exit_i,
    input wire logic maint_exit_to_normal_i,
    input wire logic cfg_loaded_i,
    output logic unit_reset_o,
    output logic cfg_reload_o,
    output logic [1:0] mode_o,
    output logic maint_active_o
);
    typedef struct packed {
        gmch_mode_t mode;
        logic [3:0] match;
        logic word_ok;
        logic [7:0] cmd;
        logic cmd_pend;
        logic pend_maint;
        gmch_dg_kind_t pend_kind;
        logic pend_special;
        logic drop_incr;
        logic [23:0] accum;
        logic busy;
        gmch_dg_kind_t kind;
        logic [2:0] idx;
        logic [7:0] status;
        logic [15:0] lat;
        logic [23:0] angle;
        logic ext;
        gmch_beat_t [1:0] buf_e;
        logic [1:0] buf_v;
        logic wr_sel;
        logic rd_sel;
        logic unit_reset;
        logic cfg_reload;
        logic maint;
    } gmch_dev_st_t;
    gmch_dev_st_t s_q, s_d;

    function automatic logic [2:0] gmch_len(input gmch_dg_kind_t k,
                                            input logic ext);
        case (k)
            GMCH_DG_MEAS: return ext ? 3'd6 : 3'd4; // [RL3]
            default: return 3'd2;
        endcase
    endfunction

    logic buf_full;
    logic in_ready;
    assign buf_full = &s_q.buf_v;
    assign in_ready = !buf_full;

    always_comb begin
        logic [7:0] c;
        logic [7:0] beat;
        logic special_set;
        c = link.cmd_byte;
        beat = 8'h00;
        special_set = 1'b0;
        s_d = s_q;
        s_d.unit_reset = 1'b0;
        s_d.cfg_reload = 1'b0;

        if (s_q.mode == GMCH_MODE_INIT && cfg_loaded_i) begin
            s_d.mode = GMCH_MODE_NORMAL;
        end

        // command matcher, no echo or error output [RL15]
        if (link.cmd_valid && s_q.mode == GMCH_MODE_NORMAL) begin
            if (c == GMCH_TERM) begin
                if (s_q.word_ok) begin
                    s_d.pend_maint = 1'b1; // [RL14] [RL13]
                end else if (s_q.cmd_pend) begin
                    case (s_q.cmd)
                        GMCH_CH_N: begin
                            special_set = 1'b1; // [RL17]
                            s_d.pend_kind = GMCH_DG_PART;
                        end
                        GMCH_CH_I: begin
                            special_set = 1'b1;
                            s_d.pend_kind = GMCH_DG_SERIAL;
                        end
                        GMCH_CH_C: begin
                            special_set = 1'b1;
                            s_d.pend_kind = GMCH_DG_CONFIG;
                        end
                        GMCH_CH_R: s_d.unit_reset = 1'b1; // [RL19]
                        default: ;
                    endcase
                end
                s_d.match = GMCH_MATCH_RST;
                s_d.word_ok = 1'b0;
                s_d.cmd_pend = 1'b0;
            end else begin
                // single letters valid only with matcher at reset and no letter pending [RL16]
                s_d.cmd_pend = (s_q.match == GMCH_MATCH_RST) &&
                    !s_q.cmd_pend && (c == GMCH_CH_N ||
                    c == GMCH_CH_I || c == GMCH_CH_C || c == GMCH_CH_R);
                s_d.cmd = c;
                s_d.word_ok = 1'b0;
                if (!s_q.word_ok && int'(s_q.match) < GMCH_WORD_LEN &&
                    c == GMCH_MAINT_WORD[8*(GMCH_WORD_LEN-1-
                        int'(s_q.match)) +: 8]) begin
                    s_d.match = s_q.match + 4'h1;
                    s_d.word_ok = int'(s_q.match) == GMCH_WORD_LEN - 1;
                end else begin
                    // restart; char may itself begin the word [RL22]
                    s_d.match = (c == GMCH_MAINT_WORD[87:80]) ?
                        4'h1 : GMCH_MATCH_RST;
                end
            end
        end

        // sampling keeps running in every mode [RL5]
        if (sample_valid_i) begin
            s_d.accum = s_q.accum + sample_angle_i; // [RL21]
        end

        // datagram start on a sample that arrives while no datagram is being built
        if (!s_q.busy && sample_valid_i) begin
            if (s_q.pend_maint) begin
                s_d.mode = GMCH_MODE_MAINT; // [RL20]
                s_d.pend_maint = 1'b0;
                s_d.busy = 1'b1;
                s_d.kind = GMCH_DG_INFO; // [RL4]
                s_d.idx = 3'd0;
            end else if (s_q.mode == GMCH_MODE_NORMAL) begin
                s_d.busy = 1'b1;
                s_d.idx = 3'd0;
                s_d.ext = ext_trigger_i;
                s_d.status = check_fail_i; // [RL10] [RL11]
                s_d.lat = latency_us_i; // [RL1]
                if (s_q.pend_special) begin
                    s_d.kind = s_q.pend_kind; // [RL17]
                    s_d.pend_special = 1'b0;
                    s_d.drop_incr = incr_angle_mode_i;
                end else begin
                    s_d.kind = GMCH_DG_MEAS;
                    s_d.angle = s_q.accum + sample_angle_i;
                    if (s_q.drop_incr) begin
                        s_d.angle = sample_angle_i; // [RL18]
                    end
                    s_d.drop_incr = 1'b0;
                end
                s_d.accum = GMCH_ANGLE_RST;
            end else begin
                s_d.accum = GMCH_ANGLE_RST; // [RL6]
            end
        end
        // a fresh request wins over the one being consumed
        if (special_set) begin
            s_d.pend_special = 1'b1; // [RL17]
        end

        // beat sequencer into the two-entry buffer
        if (s_q.busy && in_ready) begin
            case (s_q.kind)
                GMCH_DG_MEAS: begin
                    case (s_q.idx)
                        3'd0: beat = s_q.status;
                        3'd1: beat = s_q.angle[23:16];
                        3'd2: beat = s_q.angle[15:8];
                        3'd3: beat = s_q.angle[7:0];
                        3'd4: beat = s_q.lat[15:8]; // [RL2]
                        default: beat = s_q.lat[7:0];
                    endcase
                end
                default: beat = {5'h00, 3'(s_q.kind)} ^ {5'h00, s_q.idx};
            endcase
            s_d.buf_e[s_q.wr_sel].data = beat;
            s_d.buf_e[s_q.wr_sel].last =
                s_q.idx == gmch_len(s_q.kind, s_q.ext) - 3'd1;
            s_d.buf_v[s_q.wr_sel] = 1'b1;
            s_d.wr_sel = !s_q.wr_sel;
            s_d.idx = s_q.idx + 3'd1;
            if (s_q.idx == gmch_len(s_q.kind, s_q.ext) - 3'd1) begin
                s_d.busy = 1'b0;
            end
        end
        if (s_q.buf_v[s_q.rd_sel] && link.tx_ready) begin
            s_d.buf_v[s_q.rd_sel] = 1'b0;
            s_d.rd_sel = !s_q.rd_sel;
        end

        if (s_q.mode == GMCH_MODE_MAINT && maint_exit_i) begin
            s_d.mode = maint_exit_to_normal_i ? GMCH_MODE_NORMAL :
                GMCH_MODE_INIT; // [RL8] [RL9]
            s_d.cfg_reload = !maint_exit_to_normal_i;
        end
        if (s_d.unit_reset) begin
            s_d = '0; // [RL19]
            s_d.unit_reset = 1'b1;
            s_d.cfg_reload = 1'b1;
        end
        s_d.maint = s_d.mode == GMCH_MODE_MAINT;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
            s_q.cfg_reload <= 1'b1; // [RL7]
        end else if (clk_en_i) begin
            s_q <= s_d;
        end
    end

    assign link.cmd_ready = clk_en_i;
    assign link.tx_valid = s_q.buf_v[s_q.rd_sel];
    assign link.tx_byte = s_q.buf_e[s_q.rd_sel].data;
    assign link.tx_last = s_q.buf_e[s_q.rd_sel].last;
    assign unit_reset_o = s_q.unit_reset;
    assign cfg_reload_o = s_q.cfg_reload;
    assign mode_o = s_q.mode;
    assign maint_active_o = s_q.maint;
endmodule
`default_nettype wire

// >>> hdl/gmch_pkg.sv
package gmch_pkg;
    localparam logic [7:0] GMCH_TERM = 8'h0D;
    localparam logic [7:0] GMCH_CH_N = 8'h4E;
    localparam logic [7:0] GMCH_CH_I = 8'h49;
    localparam logic [7:0] GMCH_CH_C = 8'h43;
    localparam logic [7:0] GMCH_CH_R = 8'h52;
    localparam int GMCH_WORD_LEN = 11;
    localparam logic [87:0] GMCH_MAINT_WORD = 88'h534552564943454D4F4445;
    localparam logic [3:0] GMCH_MATCH_RST = 4'h0;
    localparam logic [15:0] GMCH_LAT_RST = 16'h0000;
    localparam logic [7:0] GMCH_STATUS_RST = 8'h00;
    localparam logic [23:0] GMCH_ANGLE_RST = 24'h000000;

    typedef enum logic [2:0] {
        GMCH_DG_MEAS,
        GMCH_DG_PART,
        GMCH_DG_SERIAL,
        GMCH_DG_CONFIG,
        GMCH_DG_INFO
    } gmch_dg_kind_t;

    typedef enum logic [1:0] {
        GMCH_MODE_INIT,
        GMCH_MODE_NORMAL,
        GMCH_MODE_MAINT
    } gmch_mode_t;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } gmch_beat_t;
endpackage

// >>> hdl/gmch_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface gmch_link_if;
    logic cmd_valid;
    logic [7:0] cmd_byte;
    logic cmd_ready;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic tx_last;
    logic tx_ready;
    modport device (
        input cmd_valid, cmd_byte, tx_ready,
        output cmd_ready, tx_valid, tx_byte, tx_last
    );
    modport host (
        output cmd_valid, cmd_byte, tx_ready,
        input cmd_ready, tx_valid, tx_byte, tx_last
    );
endinterface
`default_nettype wire

// >>> hdl/gmch_host.sv
`timescale 1ns/100ps
`default_nettype none
// host end: sends upper-case command bytes, collects datagram bytes
module gmch_host
    import gmch_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    gmch_link_if.host link,
    input wire logic send_valid_i,
    input wire logic [7:0] send_byte_i,
    output logic send_ready_o,
    input wire logic rx_ready_i,
    output logic rx_valid_o,
    output logic [7:0] rx_byte_o,
    output logic rx_last_o
);
    typedef struct packed {
        logic cv;
        logic [7:0] cb;
        logic rv;
        logic [7:0] rb;
        logic rl;
    } gmch_host_st_t;
    gmch_host_st_t s_q, s_d;

    function automatic logic [7:0] gmch_upper(input logic [7:0] c);
        if (c >= 8'h61 && c <= 8'h7A) begin
            return c - 8'h20;
        end
        return c;
    endfunction

    always_comb begin
        s_d = s_q;
        if (s_q.cv && link.cmd_ready) begin
            s_d.cv = 1'b0;
        end
        if (!s_d.cv && send_valid_i) begin
            s_d.cv = 1'b1;
            s_d.cb = gmch_upper(send_byte_i); // [RL12]
        end
        if (s_q.rv && rx_ready_i) begin
            s_d.rv = 1'b0;
        end
        if (!s_d.rv && link.tx_valid) begin
            s_d.rv = 1'b1;
            s_d.rb = link.tx_byte;
            s_d.rl = link.tx_last;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else if (clk_en_i) begin
            s_q <= s_d;
        end
    end

    assign link.cmd_valid = s_q.cv;
    assign link.cmd_byte = s_q.cb;
    assign link.tx_ready = clk_en_i && (!s_q.rv || rx_ready_i);
    assign send_ready_o = !s_q.cv;
    assign rx_valid_o = s_q.rv;
    assign rx_byte_o = s_q.rb;
    assign rx_last_o = s_q.rl;
endmodule
`default_nettype wire

// >>> sim/gmch_link_properties.sv
`timescale 1ns/100ps
`default_nettype none
module gmch_link_properties
    import gmch_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_last,
    input wire logic tx_ready,
    input wire logic [1:0] mode_o,
    input wire logic maint_active_o,
    input wire logic unit_reset_o,
    input wire logic cfg_reload_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    chk_tx_hold: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte)
        && $stable(tx_last))
        else $error("tx beat changed while stalled");
    chk_maint_flag: assert property (
        maint_active_o == (mode_o == GMCH_MODE_MAINT))
        else $error("maintenance flag disagrees with mode");
    chk_mode_legal: assert property (mode_o != 2'h3)
        else $error("mode outside its encoding");
    chk_reset_pulse: assert property (
        unit_reset_o |=> !unit_reset_o)
        else $error("unit reset longer than one cycle");
    chk_reset_init: assert property (
        unit_reset_o |-> ##[0:3] mode_o == GMCH_MODE_INIT)
        else $error("unit reset did not reach init");
    chk_reload_init: assert property (
        cfg_reload_o |-> mode_o == GMCH_MODE_INIT)
        else $error("reload outside init");
    chk_maint_entry: assert property (
        $changed(mode_o) && mode_o == GMCH_MODE_MAINT
        |-> $past(mode_o) == GMCH_MODE_NORMAL)
        else $error("maintenance entered from wrong mode");
    chk_reset_on_term: assert property (
        unit_reset_o |-> $past(cmd_valid) && $past(cmd_byte) == GMCH_TERM)
        else $error("unit reset without terminator");
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import gmch_pkg::*;
    logic clock_i, rst_n_i, send_valid_i, send_ready_o, rx_ready_i;
    logic rx_valid_o, rx_last_o, sample_valid_i, ext_trigger_i;
    logic incr_angle_mode_i, maint_exit_i, maint_exit_to_normal_i;
    logic cfg_loaded_i, unit_reset_o, cfg_reload_o, maint_active_o;
    logic [7:0] send_byte_i, rx_byte_o, check_fail_i;
    logic [23:0] sample_angle_i;
    logic [15:0] latency_us_i;
    logic [1:0] mode_o;
    logic [8:0] q[$];
    int n_mismatch = 0;
    int cmp_count = 0;
    int rst_seen = 0;
    gmch_link_if link();
    gmch_host u_gmch_host(.clock_i(clock_i), .rst_n_i(rst_n_i),
        .clk_en_i(1'b1), .link(link), .send_valid_i(send_valid_i),
        .send_byte_i(send_byte_i), .send_ready_o(send_ready_o),
        .rx_ready_i(rx_ready_i), .rx_valid_o(rx_valid_o),
        .rx_byte_o(rx_byte_o), .rx_last_o(rx_last_o));
    gmch_device u_gmch_device(.clock_i(clock_i), .rst_n_i(rst_n_i),
        .clk_en_i(1'b1), .link(link), .sample_valid_i(sample_valid_i),
        .sample_angle_i(sample_angle_i), .check_fail_i(check_fail_i),
        .ext_trigger_i(ext_trigger_i), .latency_us_i(latency_us_i),
        .incr_angle_mode_i(incr_angle_mode_i), .maint_exit_i(maint_exit_i),
        .maint_exit_to_normal_i(maint_exit_to_normal_i),
        .cfg_loaded_i(cfg_loaded_i), .unit_reset_o(unit_reset_o),
        .cfg_reload_o(cfg_reload_o), .mode_o(mode_o),
        .maint_active_o(maint_active_o));
    gmch_link_properties u_gmch_link_properties(.clock_i(clock_i),
        .rst_n_i(rst_n_i), .cmd_valid(link.cmd_valid),
        .cmd_byte(link.cmd_byte),
        .tx_valid(link.tx_valid), .tx_byte(link.tx_byte),
        .tx_last(link.tx_last), .tx_ready(link.tx_ready), .mode_o(mode_o),
        .maint_active_o(maint_active_o), .unit_reset_o(unit_reset_o),
        .cfg_reload_o(cfg_reload_o));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1)
            q.push_back({rx_last_o, rx_byte_o});
        if (unit_reset_o === 1'b1)
            rst_seen++;
    end
    task check(input string what, input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task close_out;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task send_b(input logic [7:0] b);
        send_valid_i <= 1'b1;
        send_byte_i <= b;
        do @(posedge clock_i); while (send_ready_o !== 1'b1);
        send_valid_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task send_cmd(input string s, input bit term);
        for (int i = 0; i < s.len(); i++)
            send_b(s[i]);
        if (term)
            send_b(GMCH_TERM);
    endtask
    task send_word(input int n, input bit term);
        for (int i = 0; i < n; i++)
            send_b(GMCH_MAINT_WORD[8*(GMCH_WORD_LEN-1-i) +: 8]);
        if (term)
            send_b(GMCH_TERM);
    endtask
    task sample(input logic [23:0] a);
        sample_angle_i <= a;
        sample_valid_i <= 1'b1;
        @(posedge clock_i);
        sample_valid_i <= 1'b0;
        @(posedge clock_i);
    endtask
    // waits for a whole datagram, then judges its length
    task get_dg(input int len);
        for (int k = 0; k < 300; k++) begin
            if (q.size() > 0 && q[q.size() - 1][8] === 1'b1)
                break;
            @(posedge clock_i);
        end
        check("datagram length", 16'(q.size()), 16'(len));
    endtask
    task quiet;
        repeat (60) @(posedge clock_i);
        check("silent link", 16'(q.size()), 16'h0000);
    endtask
    task t_meas;
        check_fail_i <= 8'hA5;
        ext_trigger_i <= 1'b1;
        latency_us_i <= 16'h12FE;
        rx_ready_i <= 1'b0;
        sample(24'h123456);
        repeat (30) @(posedge clock_i);
        rx_ready_i <= 1'b1;
        get_dg(6);
        check("status", 16'(q[0][7:0]), 16'h00A5);
        check("angle", {q[1][7:0], q[3][7:0]}, 16'h1256);
        check("latency", {q[4][7:0], q[5][7:0]}, 16'h12FE);
        q.delete();
        check_fail_i <= 8'h00;
        ext_trigger_i <= 1'b0;
        sample(24'h000001);
        get_dg(4);
        check("status clear", 16'(q[0][7:0]), 16'h0000);
        q.delete();
    endtask
    task t_special;
        string cmds[3] = '{"N", "I", "C"};
        incr_angle_mode_i <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            send_cmd(cmds[i], 1'b1);
            sample(24'h000100);
            // lands while the special datagram is still in flight
            sample(24'h000100);
            get_dg(2);
            check("kind", 16'(q[0][7:0]), 16'(GMCH_DG_PART + i));
            q.delete();
            sample(24'h000007);
            get_dg(4);
            check("increment", {q[2][7:0], q[3][7:0]}, 16'h0007);
            q.delete();
        end
    endtask
    task t_partial;
        send_cmd("N", 1'b0);
        sample(24'h000002);
        get_dg(4);
        q.delete();
        send_b(8'h58);
        send_word(GMCH_WORD_LEN - 1, 1'b1);
        sample(24'h000002);
        get_dg(4);
        q.delete();
    endtask
    task enter_maint(input bit send);
        if (send)
            send_word(GMCH_WORD_LEN, 1'b1);
        sample(24'h000003);
        get_dg(2);
        check("info", 16'(q[0][7:0]), 16'(GMCH_DG_INFO));
        check("mode maint", 16'(mode_o), 16'(GMCH_MODE_MAINT));
        check("maint flag", 16'(maint_active_o), 16'h0001);
        q.delete();
    endtask
    task exit_maint(input logic to_normal, input gmch_mode_t m);
        maint_exit_to_normal_i <= to_normal;
        maint_exit_i <= 1'b1;
        @(posedge clock_i);
        maint_exit_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        check("exit mode", 16'(mode_o), 16'(m));
        check("maint flag", 16'(maint_active_o), 16'h0000);
    endtask
    task t_maint;
        // entry word arrives while a stalled datagram is in flight
        rx_ready_i <= 1'b0;
        sample(24'h000001);
        send_word(GMCH_WORD_LEN, 1'b1);
        rx_ready_i <= 1'b1;
        get_dg(4);
        check("mode held", 16'(mode_o), 16'(GMCH_MODE_NORMAL));
        q.delete();
        enter_maint(1'b0);
        sample(24'h000004);
        send_cmd("N", 1'b1);
        sample(24'h000004);
        quiet();
        exit_maint(1'b1, GMCH_MODE_NORMAL);
        sample(24'h000005);
        get_dg(4);
        q.delete();
        enter_maint(1'b1);
        cfg_loaded_i <= 1'b0;
        exit_maint(1'b0, GMCH_MODE_INIT);
        cfg_loaded_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        enter_maint(1'b1);
        rst_n_i <= 1'b0;
        @(posedge clock_i);
        check("reload", 16'(cfg_reload_o), 16'h0001);
        check("reset mode", 16'(mode_o), 16'(GMCH_MODE_INIT));
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
    endtask
    task t_reset_cmd;
        send_cmd("R", 1'b1);
        repeat (5) @(posedge clock_i);
        check("unit reset", 16'(rst_seen), 16'h0001);
    endtask
    initial begin
        #200000;
        n_mismatch++;
        close_out();
    end
    initial begin
        {rst_n_i, send_valid_i, sample_valid_i, ext_trigger_i} = 4'h0;
        {incr_angle_mode_i, maint_exit_i, maint_exit_to_normal_i} = 3'h0;
        {cfg_loaded_i, send_byte_i, check_fail_i} = 17'h00000;
        {sample_angle_i, latency_us_i} = 40'h0000000000;
        rx_ready_i = 1'b1;
        repeat (5) @(posedge clock_i);
        check("reload in reset", 16'(cfg_reload_o), 16'h0001);
        rst_n_i <= 1'b1;
        cfg_loaded_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        check("mode normal", 16'(mode_o), 16'(GMCH_MODE_NORMAL));
        t_meas();
        t_special();
        t_partial();
        t_maint();
        t_reset_cmd();
        close_out();
    end
endmodule
`default_nettype wire
